// file: rtl/psrfp_pkg.sv
// Constants and carrier types for the flyback fault-protection sequencer.
// Assumes a single 200 MHz reference clock; all thresholds are analog comparators outside.
`default_nettype none

package psrfp_pkg;

  // Clock and timebase
  localparam int CLK_MHZ          = 200;
  localparam int TICK_US          = 1000;
  localparam int TICK_CYCLES      = TICK_US * CLK_MHZ;
  // Low-feedback qualification interval, in timebase ticks (ms)
  localparam int SHORT_QUALIFY_MS = 128;
  localparam int DIV_W            = 24;
  localparam int MS_W             = 8;

  // Comparator levels, all synchronous to the clock
  typedef struct packed {
    logic fb_below_short;     // feedback under feedback_short_threshold
    logic fb_above_ovp;       // feedback over feedback_overvoltage_threshold
    logic temp_trip;          // junction at or above the trip point
    logic temp_above_recover; // junction still above the recovery point
    logic supply_startup;     // supply at startup_supply_threshold
    logic supply_lockout;     // supply at undervoltage_lockout
  } psrfp_sense_s;

  typedef struct packed {
    logic short_circuit_protection;
    logic output_overvoltage_protection;
    logic over_temperature;
  } psrfp_fault_s;

  localparam psrfp_fault_s FAULT_NONE = '{default: 1'b0};

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_SHORT_HICCUP,
    ST_OVP_DISCHARGE,
    ST_OTP_HOLD
  } psrfp_state_e;

endpackage : psrfp_pkg

`default_nettype wire

// file: rtl/psrfp_sequencer.sv
// Fault-protection sequencer: short-circuit hiccup, overvoltage discharge to lockout and restart, over-temperature hold.
// Assumes comparator levels arrive synchronous to i_ref_clk; the power stage follows o_switch_en.
// Function
// RULE_01 - A short-circuit fault is declared only after feedback stays under the short level for 128 ms.
// RULE_02 - On a short-circuit fault switching stops at once and the supply hiccups until feedback recovers.
// RULE_03 - The power stage must lift feedback over the short level within 18 ms of a normal start.
// RULE_04 - Short qualification starts when the supply reaches start-up; good feedback means no fault.
// RULE_05 - Overvoltage stops switching at once and keeps a load on the supply until lockout.
// RULE_06 - After the overvoltage discharge reaches lockout a full new start-up follows.
// RULE_07 - Switching stops at once when the junction reaches the trip temperature.
// RULE_08 - If the junction cools to the recovery point before lockout, switching resumes directly.
// RULE_09 - Reaching lockout while still hot leads to hiccup restarts until the junction has cooled.
// RULE_10 - The qualification timer clears whenever feedback rises over the short level.
// RULE_11 - Undervoltage lockout resets all fault states and timers before each new start.
`default_nettype none

module psrfp_sequencer
  import psrfp_pkg::*;
#(
  parameter int P_TICK_CYCLES  = TICK_CYCLES,
  parameter int P_SHORT_TICKS  = SHORT_QUALIFY_MS
)
(
  // Clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_reset,
  // Comparator levels
  input  wire psrfp_sense_s i_sense,
  // Power stage control
  output logic              o_switch_en,
  output logic              o_discharge_hold,
  // Fault status
  output psrfp_fault_s      o_fault
);

  psrfp_state_e         state_q, state_d;
  logic [DIV_W-1:0]     div_q, div_d;
  logic [MS_W-1:0]      ms_q, ms_d;
  logic                 tick;
  logic                 short_done;
  logic                 switch_d;
  logic                 discharge_d;
  psrfp_fault_s         fault_d;

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(P_TICK_CYCLES - 1);
  localparam logic [MS_W-1:0]  MS_LAST  = MS_W'(P_SHORT_TICKS - 1);

  assign tick       = (div_q == DIV_LAST);
  assign short_done = tick && (ms_q == MS_LAST);

  // Sequencer state
  always_comb
  begin
    state_d = state_q;
    if (i_sense.supply_lockout)
    begin
      state_d = ST_IDLE; // RULE_11
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (i_sense.supply_startup)
          begin
            // Hot restart holds without switching until the junction cools or lockout
            if (i_sense.temp_above_recover)
            begin
              state_d = ST_OTP_HOLD; // RULE_09
            end
            else
            begin
              state_d = ST_RUN; // RULE_04
            end
          end
        end
        ST_RUN:
        begin
          if (i_sense.fb_above_ovp)
          begin
            state_d = ST_OVP_DISCHARGE; // RULE_05
          end
          else if (i_sense.temp_trip)
          begin
            state_d = ST_OTP_HOLD; // RULE_07
          end
          else if (i_sense.fb_below_short && short_done)
          begin
            state_d = ST_SHORT_HICCUP; // RULE_01
          end
        end
        ST_SHORT_HICCUP:
        begin
          state_d = ST_SHORT_HICCUP; // RULE_02
        end
        ST_OVP_DISCHARGE:
        begin
          state_d = ST_OVP_DISCHARGE; // RULE_06
        end
        ST_OTP_HOLD:
        begin
          if (!i_sense.temp_above_recover && !i_sense.temp_trip)
          begin
            state_d = ST_RUN; // RULE_08
          end
        end
        default:
        begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Qualification timebase; the divider restarts with the interval so 128 ticks are whole ms
  always_comb
  begin
    div_d = '0;
    ms_d  = '0;
    if (state_q == ST_RUN && state_d == ST_RUN && i_sense.fb_below_short) // RULE_10
    begin
      div_d = tick ? '0 : div_q + DIV_W'(1);
      ms_d  = tick ? ms_q + MS_W'(1) : ms_q;
    end
    // Otherwise both clear: feedback good, lockout, or leaving run
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      div_q <= '0;
      ms_q  <= '0;
    end
    else
    begin
      div_q <= div_d;
      ms_q  <= ms_d;
    end
  end

  // Outputs follow the next state so they change in the same edge as the state
  always_comb
  begin
    switch_d    = (state_d == ST_RUN);
    // Bias kept on so the supply capacitor really decays to lockout
    discharge_d = (state_d == ST_OVP_DISCHARGE); // RULE_05
    fault_d     = FAULT_NONE;
    fault_d.short_circuit_protection      = (state_d == ST_SHORT_HICCUP);
    fault_d.output_overvoltage_protection = (state_d == ST_OVP_DISCHARGE);
    fault_d.over_temperature              = (state_d == ST_OTP_HOLD);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_switch_en      <= 1'b0;
      o_discharge_hold <= 1'b0;
      o_fault          <= FAULT_NONE;
    end
    else
    begin
      o_switch_en      <= switch_d;
      o_discharge_hold <= discharge_d;
      o_fault          <= fault_d;
    end
  end

  short_entry_time_a : assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE_01
    (state_q == ST_RUN) ##1 (state_q == ST_SHORT_HICCUP) |-> $past(ms_q) == MS_LAST && $past(tick))
    else $error("short fault taken before full interval");

  short_hiccup_stop_a : assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE_02
    (state_q == ST_SHORT_HICCUP) |-> !o_switch_en && o_fault.short_circuit_protection)
    else $error("switching during short hiccup");

  run_timer_fresh_a : assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE_04
    $rose(state_q == ST_RUN) |-> ms_q == '0 && div_q == '0 && o_switch_en)
    else $error("qualification not fresh at start");

  ovp_stop_a : assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE_05
    (state_q == ST_RUN && i_sense.fb_above_ovp && !i_sense.supply_lockout)
    |=> !o_switch_en && o_discharge_hold [*1] ##0 o_fault.output_overvoltage_protection)
    else $error("overvoltage did not stop switching");

  ovp_restart_a : assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE_06
    (state_q == ST_OVP_DISCHARGE && i_sense.supply_lockout)
    |=> state_q == ST_IDLE && !o_discharge_hold)
    else $error("overvoltage discharge did not restart");

  otp_stop_a : assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE_07
    (state_q == ST_RUN && i_sense.temp_trip && !i_sense.supply_lockout) |=> !o_switch_en)
    else $error("switching past trip temperature");

  otp_recover_a : assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE_08
    (state_q == ST_OTP_HOLD && !i_sense.temp_above_recover && !i_sense.temp_trip
     && !i_sense.supply_lockout) |=> o_switch_en && !o_fault.over_temperature)
    else $error("no direct resume after cooling");

  otp_hiccup_a : assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE_09
    (state_q == ST_IDLE && i_sense.supply_startup && i_sense.temp_above_recover
     && !i_sense.supply_lockout) |=> !o_switch_en && o_fault.over_temperature)
    else $error("hot restart began switching");

  timer_clear_a : assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE_10
    (!i_sense.fb_below_short) |=> ms_q == '0 && div_q == '0)
    else $error("qualification timer kept counting");

  lockout_reset_a : assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE_11
    i_sense.supply_lockout |=> state_q == ST_IDLE && ms_q == '0 && o_fault == FAULT_NONE && !o_switch_en)
    else $error("lockout did not reset sequencer");

endmodule : psrfp_sequencer

`default_nettype wire

// file: test/psrfp_stage_model.sv
// Flyback stage model: supply capacitor and feedback comparators.
// Assumes the sequencer's switch enable; fault conditions come from bench commands.
`default_nettype none
module psrfp_stage_model
(
  // Clock and sequencer control
  input  wire logic i_ref_clk,
  input  wire logic i_switch_en,
  // Bench fault commands
  input  wire logic i_short_cmd,
  input  wire logic i_ovp_cmd,
  // Comparator levels
  output logic      o_fb_below,
  output logic      o_fb_above,
  output logic      o_startup,
  output logic      o_lockout
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] vcc_q = 4'h0;
  logic       chg_q = 1'b1;
  always @(posedge i_ref_clk)
  begin
    // Winding holds the supply only while switching
    if (chg_q && vcc_q != 4'hf) vcc_q <= vcc_q + 4'h1;
    else if (!chg_q && !i_switch_en && vcc_q != 4'h0) vcc_q <= vcc_q - 4'h1;
    if (vcc_q == 4'hf) chg_q <= 1'b0;
    else if (vcc_q == 4'h0) chg_q <= 1'b1;
  end
  // Healthy output lifts feedback at once
  assign o_fb_below = i_short_cmd;
  assign o_fb_above = i_ovp_cmd;
  assign o_startup  = vcc_q == 4'hf;
  assign o_lockout  = vcc_q == 4'h0;
endmodule : psrfp_stage_model
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the fault-protection sequencer.
// Assumes the stage model closes the supply loop; temperature comes from the bench.
`default_nettype none
module tb_top import psrfp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TK = 4;
  localparam int NQ = 3;
  localparam logic [4:0] IDLE = 5'h00, RUN = 5'h02, SHORT = 5'h10, OUTPUT_OVERVOLTAGE_PROTECTION = 5'h09, OTP = 5'h04;
  typedef struct packed { logic [4:0] vec; logic [7:0] gap; } psrfp_note_s;
  logic         i_ref_clk = 1'b0;
  logic         i_reset   = 1'b1;
  logic         short_cmd = 1'b0;
  logic         ovp_cmd   = 1'b0;
  logic         trip      = 1'b0;
  logic         hot       = 1'b0;
  logic         o_switch_en, o_discharge_hold, fb_below, fb_above, startup, lockout;
  psrfp_fault_s o_fault;
  psrfp_note_s  notes[$];
  logic [4:0]   prev_q = 5'h00;
  logic [31:0]  seed = 32'hf9f9_36c0;
  int           err_total = 0;
  int           n_tests = 0;
  int           gap = 0;
  always #2.5 i_ref_clk = ~i_ref_clk;
  psrfp_sequencer #(.P_TICK_CYCLES(TK), .P_SHORT_TICKS(NQ)) uut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .i_sense({fb_below, fb_above, trip, hot, startup, lockout}), .o_switch_en(o_switch_en),
    .o_discharge_hold(o_discharge_hold), .o_fault(o_fault));
  psrfp_stage_model stage (.i_ref_clk(i_ref_clk), .i_switch_en(o_switch_en), .i_short_cmd(short_cmd),
    .i_ovp_cmd(ovp_cmd), .o_fb_below(fb_below), .o_fb_above(fb_above), .o_startup(startup), .o_lockout(lockout));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check_outputs(input string what, input logic [4:0] exp, input logic [4:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check_outputs
  task automatic check_delay(input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH short delay expected %0d seen %0d", exp, got);
    end
  endtask : check_delay
  task automatic check_drain(input int left);
    n_tests++;
    if (left != 0)
    begin
      err_total++;
      $display("MISMATCH pending notes expected %0d seen %0d", 0, left);
    end
  endtask : check_drain
  task automatic expect_out(input logic [4:0] vec, input logic [7:0] gap_cyc);
    notes.push_back({vec, gap_cyc});
  endtask : expect_out
  task automatic drain();
    int n = 0;
    while (notes.size() != 0 && n < 2000)
    begin
      @(negedge i_ref_clk);
      n++;
    end
    check_drain(notes.size());
  endtask : drain
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // Each output change consumes the oldest note
  always @(posedge i_ref_clk)
  begin
    psrfp_note_s note;
    logic [4:0]  now_v;
    #1;
    now_v = {o_fault, o_switch_en, o_discharge_hold};
    gap++;
    if (!i_reset && now_v !== prev_q)
    begin
      // Unannounced change always fails: the outputs should have held
      if (notes.size() == 0) check_outputs("unexpected change", prev_q, now_v);
      else
      begin
        note = notes.pop_front();
        check_outputs("outputs", note.vec, now_v);
        if (note.gap != 8'hff) check_delay(note.gap, gap[7:0]);
      end
      prev_q = now_v;
      gap = 0;
    end
  end
  initial
  begin : main
    int len;
    repeat (10) @(negedge i_ref_clk);
    check_outputs("reset outputs", 5'h00, {o_fault, o_switch_en, o_discharge_hold});
    i_reset = 1'b0;
    expect_out(RUN, 8'hff);
    drain();
    // Low bursts one to four cycles short of the limit
    repeat (8)
    begin
      seed = lfsr(seed);
      len = NQ * TK - 1 - int'(seed[1:0]);
      short_cmd = 1'b1;
      repeat (len) @(negedge i_ref_clk);
      short_cmd = 1'b0;
      @(negedge i_ref_clk);
    end
    expect_out(SHORT, 8'hff);
    expect_out(IDLE, 8'hff);
    expect_out(RUN, 8'hff);
    expect_out(SHORT, 8'(NQ * TK));
    expect_out(IDLE, 8'hff);
    short_cmd = 1'b1;
    drain();
    short_cmd = 1'b0;
    expect_out(RUN, 8'hff);
    drain();
    expect_out(OUTPUT_OVERVOLTAGE_PROTECTION, 8'hff);
    expect_out(IDLE, 8'hff);
    expect_out(RUN, 8'hff);
    ovp_cmd = 1'b1;
    @(negedge i_ref_clk);
    ovp_cmd = 1'b0;
    drain();
    expect_out(OTP, 8'hff);
    expect_out(RUN, 8'hff);
    {trip, hot} = 2'b11;
    @(negedge i_ref_clk);
    trip = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    hot = 1'b0;
    drain();
    expect_out(OTP, 8'hff);
    expect_out(IDLE, 8'hff);
    expect_out(OTP, 8'hff);
    {trip, hot} = 2'b11;
    @(negedge i_ref_clk);
    trip = 1'b0;
    drain();
    hot = 1'b0;
    expect_out(RUN, 8'hff);
    drain();
    print_verdict();
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    err_total++;
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
